// ### bench/opb_core_model.sv
// Core-side model: I/O strobes, branch ops and vector acks.
// Assumes the block samples everything on the rising edge of ref_clk.
`default_nettype none
module opb_core_model (
  input wire logic ref_clk,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_addr,
  output logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic io_rvalid,
  output logic [3:0] branch_op,
  input wire logic branch_taken,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 8'h00;
    io_wdata = 16'h0000;
    branch_op = 4'h0;
    irq_ack = 1'b0;
  end
  // Signals always move 2 ns after an edge
  task automatic step();
    @(posedge ref_clk);
    #2;
  endtask
  // One write strobe; released address and data flip so stale values never match.
  // An idle edge follows, so a next request never re-raises in the same step.
  task automatic io_write(input logic [7:0] a, input logic [15:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    step();
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
    step();
  endtask
  // One read strobe, then a bounded wait for the answer
  task automatic io_read(input logic [7:0] a, output logic [15:0] d, output logic ok);
    io_addr = a;
    io_rd = 1'b1;
    step();
    io_rd = 1'b0;
    io_addr = ~a;
    ok = 1'b0;
    d = 16'h0000;
    repeat (4) begin
      if (!ok && io_rvalid === 1'b1) begin
        d = io_rdata;
        ok = 1'b1;
      end
      if (!ok) step();
    end
    step();
  endtask
  // Branch op driven until the next call; ops may run back to back
  task automatic branch(input logic [3:0] op, output logic taken);
    branch_op = op;
    step();
    taken = branch_taken;
  endtask
  // Accept the presented vector
  task automatic ack();
    irq_ack = 1'b1;
    step();
    irq_ack = 1'b0;
    step();
  endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the output port, branch flags and interrupts.
// Assumes opb_top and the core model; pins and timers are driven here.
`default_nettype none
module testbench
  import opb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst_n, io_wr, io_rd, io_rvalid, cmp_enable, cmp_flag_in;
  logic cmp_irq_rise_in, cmp_irq_fall_in, sample_timer_uf, first_timer_uf;
  logic second_timer_uf, deep_sleep, wake_arm, branch_taken, irq_req, irq_ack, wake_req;
  logic [7:0] io_addr, port_d_pins, port_f_pins, irq_enable, irq_pending;
  logic [15:0] io_wdata, io_rdata, out_port_pins, irq_vector;
  logic [3:0] branch_op;
  int failures = 0;
  int cmp_count = 0;
  opb_top u_dut (.ref_clk, .rst_n, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
    .io_rvalid, .out_port_pins, .port_d_pins, .port_f_pins, .cmp_enable, .cmp_flag_in,
    .cmp_irq_rise_in, .cmp_irq_fall_in, .sample_timer_uf, .first_timer_uf,
    .second_timer_uf, .irq_enable, .deep_sleep, .wake_arm, .branch_op, .branch_taken,
    .irq_req, .irq_vector, .irq_ack, .wake_req, .irq_pending);
  opb_core_model u_core (.ref_clk, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
    .io_rvalid, .branch_op, .branch_taken, .irq_ack);
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    $display("Error watchdog expected done seen hang");
    results();
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait for a request level
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    while (irq_req !== lvl && n < 10) begin
      tick(1);
      n++;
    end
    check("irq_req wait", 16'(lvl), 16'(irq_req));
    if (irq_req !== lvl) results();
  endtask
  // Expect vector of index i, accept it, see its latch clear; the request
  // stays up when another enabled source is still pending
  task automatic take_vec(input int i);
    wait_req(1'b1);
    check("irq_vector", 16'h7FF0 + 16'(i), irq_vector);
    u_core.ack();
    check("irq_pending clr", 16'h0000, 16'(irq_pending[i]));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset, asserted mid-run too
  task automatic t_reset();
    rst_n = 1'b0;
    tick(2);
    check("out_port_pins rst", 16'h0000, out_port_pins);
    check("irq_req rst", 16'h0000, 16'(irq_req));
    rst_n = 1'b1;
    tick(2);
    check("out_port_pins after", 16'h0000, out_port_pins);
    $display("Test reset done");
  endtask
  // Register writes, readback and an unmapped address
  task automatic t_port();
    logic [15:0] d;
    logic ok;
    u_core.io_write(8'h2C, 16'hA5C3);
    check("out_port_pins", 16'hA5C3, out_port_pins);
    u_core.io_read(8'h2C, d, ok);
    check("rdata 2C", 16'hA5C3, ok ? d : 16'hDEAD);
    u_core.io_write(8'h28, 16'h0F0F);
    u_core.io_read(8'h28, d, ok);
    check("rdata 28", 16'h0000, ok ? d : 16'hDEAD);
    check("pins kept", 16'hA5C3, out_port_pins);
    u_core.io_write(8'h2C, 16'h8001);
    check("pins end bits", 16'h8001, out_port_pins);
    $display("Test port done");
  endtask
  // Every branch op against every level of the two flag pins
  task automatic t_branch();
    logic t, f;
    for (int lv = 0; lv < 4; lv++) begin
      port_d_pins = 8'h28 | 8'(lv);
      tick(4);
      for (int op = 0; op < 16; op++) begin
        u_core.branch(4'(op), t);
        f = op[0] ? lv[1] : lv[0];
        check("branch_taken", 16'(op[3] & (op[1] ^ f)), 16'(t));
      end
    end
    u_core.branch(4'h0, t);
    $display("Test branch done");
  endtask
  // All eight sources fire masked, then drain in priority order
  task automatic t_irq();
    check("irq_pending idle", 16'h0000, 16'(irq_pending));
    port_d_pins = 8'h14;
    port_f_pins = 8'hFE;
    sample_timer_uf = 1'b1;
    first_timer_uf = 1'b1;
    second_timer_uf = 1'b1;
    tick(1);
    sample_timer_uf = 1'b0;
    first_timer_uf = 1'b0;
    second_timer_uf = 1'b0;
    tick(5);
    check("irq_pending all", 16'h00FF, 16'(irq_pending));
    check("irq_req masked", 16'h0000, 16'(irq_req));
    irq_enable = 8'hFF;
    for (int i = 0; i < 8; i++) take_vec(i);
    check("irq_req drained", 16'h0000, 16'(irq_req));
    $display("Test irq done");
  endtask
  // Keyscan only from the all-high pattern, re-armed by all high
  task automatic t_key();
    port_f_pins = 8'hFC;
    tick(5);
    check("keyscan held low", 16'h0000, 16'(irq_pending));
    port_f_pins = 8'hFF;
    tick(5);
    port_f_pins = 8'h7F;
    tick(5);
    check("keyscan rearm", 16'h0020, 16'(irq_pending));
    take_vec(5);
    $display("Test keyscan done");
  endtask
  // Comparator takes flag b and slots six and seven
  task automatic t_cmp();
    logic t;
    cmp_enable = 1'b1;
    cmp_flag_in = 1'b1;
    port_d_pins = 8'h20;
    tick(5);
    port_d_pins = 8'h10;
    tick(5);
    check("pins ignored", 16'h0000, 16'(irq_pending));
    u_core.branch(4'h9, t);
    check("flag b cmp", 16'h0001, 16'(t));
    u_core.branch(4'h0, t);
    cmp_irq_rise_in = 1'b1;
    cmp_irq_fall_in = 1'b1;
    tick(1);
    cmp_irq_rise_in = 1'b0;
    cmp_irq_fall_in = 1'b0;
    tick(5);
    check("cmp pending", 16'h00C0, 16'(irq_pending));
    take_vec(6);
    take_vec(7);
    $display("Test comparator done");
  endtask
  // Wake needs enable, and the arm bit in deep sleep
  task automatic t_wake();
    irq_enable = 8'h00;
    deep_sleep = 1'b1;
    first_timer_uf = 1'b1;
    tick(1);
    first_timer_uf = 1'b0;
    tick(4);
    check("wake masked", 16'h0000, 16'(wake_req));
    irq_enable = 8'h02;
    tick(3);
    check("wake unarmed", 16'h0000, 16'(wake_req));
    wake_arm = 1'b1;
    tick(3);
    check("wake armed", 16'h0001, 16'(wake_req));
    deep_sleep = 1'b0;
    wake_arm = 1'b0;
    tick(3);
    check("wake light", 16'h0001, 16'(wake_req));
    take_vec(1);
    tick(3);
    check("wake cleared", 16'h0000, 16'(wake_req));
    $display("Test wake done");
  endtask
  task automatic results();
    $display("Counts: %0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {cmp_enable, cmp_flag_in, cmp_irq_rise_in, cmp_irq_fall_in} = 4'h0;
    {sample_timer_uf, first_timer_uf, second_timer_uf, deep_sleep, wake_arm} = 5'h00;
    port_d_pins = 8'h28;
    port_f_pins = 8'hFF;
    irq_enable = 8'h00;
    t_reset();
    t_port();
    t_branch();
    t_irq();
    t_key();
    t_cmp();
    t_wake();
    t_reset();
    results();
  end
endmodule
`default_nettype wire

// ### rtl/opb_pkg.sv
// Package for the output port, branch flag and interrupt source block.
// Assumes a 40 MHz CPU clock and an 8-bit I/O address from the core.
`default_nettype none
package opb_pkg;
  // I/O address of the output port data register
  localparam logic [7:0] OPB_ADDR_OUT_PORT = 8'h2C;
  // Output port width and reset value
  localparam int OPB_OUT_W = 16;
  localparam logic [15:0] OPB_OUT_RST = 16'h0000;
  // Port D bit positions
  localparam int OPB_D_FLAG_A = 0;
  localparam int OPB_D_FLAG_B = 1;
  localparam int OPB_D_D2 = 2;
  localparam int OPB_D_D3 = 3;
  localparam int OPB_D_D4 = 4;
  localparam int OPB_D_D5 = 5;
  // Interrupt indices, highest priority first
  localparam int OPB_IRQ_N = 8;
  localparam logic [2:0] OPB_IRQ_SAMPLE = 3'h0;
  localparam logic [2:0] OPB_IRQ_TMR1 = 3'h1;
  localparam logic [2:0] OPB_IRQ_TMR2 = 3'h2;
  localparam logic [2:0] OPB_IRQ_D2 = 3'h3;
  localparam logic [2:0] OPB_IRQ_D3 = 3'h4;
  localparam logic [2:0] OPB_IRQ_KEY = 3'h5;
  localparam logic [2:0] OPB_IRQ_D4 = 3'h6;
  localparam logic [2:0] OPB_IRQ_D5 = 3'h7;
  // Vector base; vector = base + index
  localparam logic [15:0] OPB_VEC_BASE = 16'h7FF0;
  // Port F all-high pattern
  localparam logic [7:0] OPB_KEY_ALL_HIGH = 8'hFF;
endpackage
`default_nettype wire

// ### rtl/opb_sync.sv
// Two-stage synchroniser for a bus of pin levels.
// Assumes one clock domain; the first stage is read only by the second.
`default_nettype none
module opb_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q; // First stage, feeds only the second
  logic [W-1:0] sync_q; // Second stage, safe to use

  // Two flops in series; reset to zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### rtl/opb_top.sv
// Output port, branch flags and eight prioritised interrupt sources.
// Assumes the core issues one-cycle I/O strobes and acks vectors it takes;
// timer underflows arrive as one-cycle pulses in the ref_clk domain.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - 16-bit output port at I/O 0x2C
// - Output port resets to all zeros
// - Port register readable; bits map onto pins
// - Flags follow port D bits 0, 1
// - Call/jump taken per flag and sense
// - Comparator enable sources flag b
// - Port D bits 2-5 raise interrupts
// - D2 rise, D3 fall, D4 rise, D5 fall
// - Keyscan fires from all-high to low
// - No keyscan while another F pin low
// - Keyscan re-arms once all F high
// - Sample timer underflow is index 0
// - Timers one, two are indices 1, 2
// - Vectors 0x7FF0-0x7FF7, lowest index first
// - Comparator enable feeds slots six, seven
// - Enabled interrupt wakes; deep sleep needs arm
// - Events during wake-up may be lost
module opb_top
  import opb_pkg::*;
#(
  parameter int OUT_W = OPB_OUT_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic io_rvalid,
  output logic [OUT_W-1:0] out_port_pins,
  input wire logic [7:0] port_d_pins,
  input wire logic [7:0] port_f_pins,
  input wire logic cmp_enable,
  input wire logic cmp_flag_in,
  input wire logic cmp_irq_rise_in,
  input wire logic cmp_irq_fall_in,
  input wire logic sample_timer_uf,
  input wire logic first_timer_uf,
  input wire logic second_timer_uf,
  input wire logic [OPB_IRQ_N-1:0] irq_enable,
  input wire logic deep_sleep,
  input wire logic wake_arm,
  input wire logic [3:0] branch_op,
  output logic branch_taken,
  output logic irq_req,
  output logic [15:0] irq_vector,
  input wire logic irq_ack,
  output logic wake_req,
  output logic [OPB_IRQ_N-1:0] irq_pending
);
  ////////////////////////////////////////////////////////////////////////////
  // Branch operation codes: bit 0 selects flag b, bit 1 negates, bit 2 jump
  typedef enum logic [3:0] {
    OPB_BR_NONE = 4'b0000,
    OPB_BR_CALL_A = 4'b1000,
    OPB_BR_CALL_B = 4'b1001,
    OPB_BR_CALL_NOT_A = 4'b1010,
    OPB_BR_CALL_NOT_B = 4'b1011,
    OPB_BR_JUMP_A = 4'b1100,
    OPB_BR_JUMP_B = 4'b1101,
    OPB_BR_JUMP_NOT_A = 4'b1110,
    OPB_BR_JUMP_NOT_B = 4'b1111
  } opb_br_t;

  // Lowest set index among requests; valid only when any bit set
  function automatic logic [2:0] opb_first(input logic [OPB_IRQ_N-1:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = OPB_IRQ_N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for port D and port F pins
  logic [7:0] d_sync; // Port D after two stages
  logic [7:0] f_sync; // Port F after two stages
  logic [7:0] d_prev_q; // Previous synchronised port D sample
  logic key_armed_q; // Port F seen all high since last trigger

  // Pins are resampled before any edge compare
  opb_sync #(.W(8)) u_sync_d (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(port_d_pins),
    .sync_out(d_sync)
  );

  opb_sync #(.W(8)) u_sync_f (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(port_f_pins),
    .sync_out(f_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output port register
  logic [OUT_W-1:0] out_q; // Port data, drives pins directly
  logic wr_hit; // Write strobe addressed to the port

  assign wr_hit = io_wr && (io_addr == OPB_ADDR_OUT_PORT);

  // Register written by OUT; reset clears every pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= OPB_OUT_RST[OUT_W-1:0];
    end else if (wr_hit) begin
      out_q <= io_wdata[OUT_W-1:0];
    end
  end

  assign out_port_pins = out_q;

  // Read-back path; other addresses belong to other blocks and read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 16'h0000;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      if (io_rd && io_addr == OPB_ADDR_OUT_PORT) begin
        io_rdata <= 16'(out_q);
      end else begin
        io_rdata <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Branch flags; pin level counts whatever the pin direction
  logic flag_a; // Flag a, true when high
  logic flag_b; // Flag b, pin or comparator
  logic br_cond; // Selected flag after sense
  opb_br_t br_op; // Decoded branch request

  assign flag_a = d_sync[OPB_D_FLAG_A];
  assign flag_b = cmp_enable ? cmp_flag_in : d_sync[OPB_D_FLAG_B];
  assign br_op = opb_br_t'(branch_op);

  // Pick flag, then apply positive or negated sense
  always_comb begin
    br_cond = 1'b0;
    unique case (br_op)
      OPB_BR_NONE: br_cond = 1'b0;
      OPB_BR_CALL_A, OPB_BR_JUMP_A: br_cond = flag_a;
      OPB_BR_CALL_B, OPB_BR_JUMP_B: br_cond = flag_b;
      OPB_BR_CALL_NOT_A, OPB_BR_JUMP_NOT_A: br_cond = !flag_a;
      OPB_BR_CALL_NOT_B, OPB_BR_JUMP_NOT_B: br_cond = !flag_b;
      default: br_cond = 1'b0; // Codes 0001-0111 are not branches
    endcase
  end

  // Registered decision, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      branch_taken <= 1'b0;
    end else begin
      branch_taken <= br_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up guard for port D edge detection
  logic [1:0] prime_q; // Edges since reset, saturates at three
  logic d_primed; // Sync stages and previous sample all hold pin values

  // The sync stages and d_prev_q reset to zero, so a pin idling high would
  // look like a rising edge just after reset. Edges are ignored until real
  // pin samples fill all three flops; an event in that short window is
  // dropped, which is tolerated around power-up.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prime_q <= 2'h0;
    end else if (prime_q != 2'h3) begin
      prime_q <= prime_q + 2'h1;
    end
  end

  assign d_primed = (prime_q == 2'h3);

  ////////////////////////////////////////////////////////////////////////////
  // Edge and keyscan event detection
  logic [OPB_IRQ_N-1:0] evt; // One-cycle event per source
  logic key_all_high; // Every F pin high this sample

  assign key_all_high = (f_sync == OPB_KEY_ALL_HIGH);

  // Previous port D sample for edge compares
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      d_prev_q <= 8'h00;
    end else begin
      d_prev_q <= d_sync;
    end
  end

  // Armed only by an all-high sample; disarmed by the trigger itself.
  // Starts disarmed, so floating keys at power-up cannot fire.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_armed_q <= 1'b0;
    end else if (key_all_high) begin
      key_armed_q <= 1'b1;
    end else begin
      key_armed_q <= 1'b0;
    end
  end

  // Gather the eight events in priority order
  always_comb begin
    evt = '0;
    evt[OPB_IRQ_SAMPLE] = sample_timer_uf;
    evt[OPB_IRQ_TMR1] = first_timer_uf;
    evt[OPB_IRQ_TMR2] = second_timer_uf;
    evt[OPB_IRQ_D2] = d_primed && d_sync[OPB_D_D2] && !d_prev_q[OPB_D_D2];
    evt[OPB_IRQ_D3] = d_primed && !d_sync[OPB_D_D3] && d_prev_q[OPB_D_D3];
    evt[OPB_IRQ_KEY] = key_armed_q && !key_all_high;
    if (cmp_enable) begin
      evt[OPB_IRQ_D4] = cmp_irq_rise_in;
      evt[OPB_IRQ_D5] = cmp_irq_fall_in;
    end else begin
      evt[OPB_IRQ_D4] = d_primed && d_sync[OPB_D_D4] && !d_prev_q[OPB_D_D4];
      evt[OPB_IRQ_D5] = d_primed && !d_sync[OPB_D_D5] && d_prev_q[OPB_D_D5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending latches, priority select and vector
  logic [OPB_IRQ_N-1:0] pend_q; // Sticky pending per source
  logic [OPB_IRQ_N-1:0] ready; // Pending and enabled
  logic [OPB_IRQ_N-1:0] ack_clr; // Source cleared by an accept
  logic [2:0] sel_idx; // Winning index

  assign ready = pend_q & irq_enable;
  assign sel_idx = opb_first(ready & ~ack_clr);

  // Accept clears the source shown on the vector output
  always_comb begin
    ack_clr = '0;
    if (irq_ack && irq_req) begin
      ack_clr[irq_vector[2:0]] = 1'b1;
    end
  end

  // New event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~ack_clr) | evt;
    end
  end

  // Request and vector stand registered; the ack cycle drops the request unless another enabled source is still pending
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_vector <= OPB_VEC_BASE;
    end else begin
      irq_req <= |(ready & ~ack_clr);
      irq_vector <= OPB_VEC_BASE | 16'(sel_idx);
    end
  end

  // Wake needs an enabled pending source; deep sleep also needs arm
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= (|ready) && (!deep_sleep || wake_arm);
    end
  end

  // Pending view; lost events during wake-up are tolerated upstream
  assign irq_pending = pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_port_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_hit |=> out_port_pins == $past(io_wdata))
    else $error("port did not take write");
  chk_port_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    io_rd && io_addr == OPB_ADDR_OUT_PORT |=> io_rdata == $past(out_port_pins))
    else $error("port read mismatch");
  chk_flag_a_sense: assert property (@(posedge ref_clk) disable iff (!rst_n)
    br_op == OPB_BR_JUMP_NOT_A |=> branch_taken == !$past(flag_a))
    else $error("negated flag a wrong");
  chk_flag_b_src: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmp_enable && br_op == OPB_BR_CALL_B |=> branch_taken == $past(cmp_flag_in))
    else $error("flag b not from comparator");
  chk_d3_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    d_primed && $fell(d_sync[OPB_D_D3]) |=> pend_q[OPB_IRQ_D3])
    else $error("d3 fall not pending");
  chk_key_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !key_all_high && !$past(key_all_high) |-> !evt[OPB_IRQ_KEY])
    else $error("keyscan fired while not armed");
  chk_prio_vec: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ready[0] && !ack_clr[0] |=> irq_req && irq_vector == OPB_VEC_BASE)
    else $error("index 0 not presented first");
  chk_pend_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ack_clr[3] && !evt[3] |=> !pend_q[3])
    else $error("pending not cleared by accept");
  chk_deep_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
    deep_sleep && !wake_arm |=> !wake_req)
    else $error("deep sleep woke without arm");
  chk_d2_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    d_primed && $rose(d_sync[OPB_D_D2]) |=> pend_q[OPB_IRQ_D2])
    else $error("d2 rise not pending");
  chk_key_fire: assert property (@(posedge ref_clk) disable iff (!rst_n)
    key_armed_q && !key_all_high |=> pend_q[OPB_IRQ_KEY])
    else $error("keyscan trigger not pending");
  chk_timer_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sample_timer_uf |=> pend_q[OPB_IRQ_SAMPLE])
    else $error("sample timer underflow not pending");
  chk_cmp_slots: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmp_enable && !cmp_irq_rise_in && !cmp_irq_fall_in |->
      !evt[OPB_IRQ_D4] && !evt[OPB_IRQ_D5])
    else $error("port pin reached a comparator slot");
  chk_flag_a_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    br_op == OPB_BR_JUMP_A |=> branch_taken == $past(d_sync[OPB_D_FLAG_A]))
    else $error("flag a does not follow pin");
  cov_key_trigger: cover property (@(posedge ref_clk) disable iff (!rst_n)
    evt[OPB_IRQ_KEY]);
  cov_ack_taken: cover property (@(posedge ref_clk) disable iff (!rst_n)
    irq_req && irq_ack);
  cov_port_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    wr_hit);
  cov_vec_chain: cover property (@(posedge ref_clk) disable iff (!rst_n)
    irq_req && irq_ack ##1 irq_req);
  cov_deep_wake: cover property (@(posedge ref_clk) disable iff (!rst_n)
    deep_sleep && wake_arm && wake_req);
endmodule
`default_nettype wire
